// ==== pkg/datapath_pkg.sv ====
// Constants, operation codes and state types for the integer datapath.
// Assumes one pipeline clock shared by issue logic and this package's users.
package datapath_pkg;

  // ==========================================================================
  // Widths
  localparam int XLEN       = 32;
  localparam int HALF_W     = 16;
  localparam int REG_ADDR_W = 5;
  localparam int BANK_IDX_W = REG_ADDR_W + 1;
  localparam int BANK_WORDS = 2 ** BANK_IDX_W;
  localparam int SHAMT_W    = 5;
  localparam int PROD_W     = 50;
  localparam int ACC_W      = 64;
  localparam int CNT_W      = 6;

  // ==========================================================================
  // Dividend width checks and early-out skips
  localparam logic [5:0] FIT_8      = 6'h08;
  localparam logic [5:0] FIT_16     = 6'h10;
  localparam logic [5:0] FIT_24     = 6'h18;
  localparam logic [5:0] SKIP_8     = 6'h17;
  localparam logic [5:0] SKIP_16    = 6'h0f;
  localparam logic [5:0] SKIP_24    = 6'h07;
  localparam logic [5:0] SKIP_32    = 6'h00;
  localparam logic [5:0] FULL_ITER  = 6'h20;

  // ==========================================================================
  // Quotient repeat rates in pipeline clocks
  localparam logic [5:0] RPT_8      = 6'h0b;
  localparam logic [5:0] RPT_16     = 6'h12;
  localparam logic [5:0] RPT_24     = 6'h19;
  localparam logic [5:0] RPT_32     = 6'h20;
  localparam logic [5:0] CNT_LAST   = 6'h01;
  localparam logic [5:0] CNT_ZERO   = 6'h00;

  // ==========================================================================
  // Operations
  typedef enum logic [4:0] {
    alu_add_op, alu_sub_op, alu_and_op, alu_or_op, alu_xor_op, alu_nor_op,
    alu_sll_op, alu_srl_op, alu_sra_op, alu_slt_op,
    count_leading_zeros_op, count_leading_ones_op,
    load_word_op, store_word_op, move_top_op, move_bottom_op,
    product_to_accumulator_op, product_add_accumulate_op,
    product_subtract_accumulate_op, product_to_register_op, quotient_op
  } op_t;

  typedef enum logic {quot_idle, quot_run} quot_state_t;

endpackage

// ==== rtl/multiply_divide_datapath.sv ====
// Integer execution datapath with its multiply/divide unit.
// Assumes the issuing pipeline honours iss_stall and memory answers in the cycle mem_re is high.
// What this block does
// - Multiply/divide unit keeps advancing even while the integer pipeline holds.
// - Multiplier takes 32-bit operand_a by 16-bit operand_b slice; result words; divide FSM.
// - Pass count depends only on operand_b width: one pass or two.
// - Short multiplies accepted every cycle, except a product to register right after a full-width one; full-width ones every second cycle.
// - Back-to-back full-width multiplies are held off by stalling the issuer.
// - Effective multiply size is found from operand values, no size input.
// - Division is iterative, one quotient bit per clock, under a state machine.
// - Dividend fitting 8, 16, 24 bits skips 23, 15, 7 iterations.
// - Moves issued while dividing stall until the division completes; products and quotients only until its last cycle.
// - Accumulator products: latency/repeat 1/1 short operand_b, 2/2 full width.
// - Product to register: latency/repeat 2/1 short, 3/2 full width.
// - Quotient latency/repeat 12/11, 19/18, 26/25, 33/32 by dividend width.
// - Thirty-two 32-bit general registers plus one full shadow bank.
// - Two read ports, one write port, full forwarding before write-back.
// - Single-cycle logic, shift, add, subtract; memory only through load/store.
// - Leading zero and leading one counter serves both count operations.
// - Forwarding muxes route fresh ALU results to following consumers without stall; a load stalls the next issue one cycle.
`timescale 1ns/1ns

module multiply_divide_datapath (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Issue from the integer pipeline
  input  wire logic                    iss_valid,
  input  wire datapath_pkg::op_t       iss_op,
  input  wire logic                    iss_signed,
  input  wire logic [4:0]              src_a_addr,
  input  wire logic [4:0]              src_b_addr,
  input  wire logic [4:0]              dst_addr,
  input  wire logic [31:0]             imm,
  input  wire logic                    use_imm,
  input  wire logic                    shadow_sel,
  input  wire logic                    iu_hold,
  output logic                         iss_stall,
  // Memory access
  output logic                         mem_re,
  output logic                         mem_we,
  output logic [31:0]                  mem_addr,
  output logic [31:0]                  mem_wdata,
  input  wire logic [31:0]             load_data,
  // Register write port
  output logic                         wb_valid,
  output logic                         wb_bank,
  output logic [4:0]                   wb_addr,
  output logic [31:0]                  wb_data,
  // Result words
  output logic [31:0]                  top_result_word,
  output logic [31:0]                  bottom_result_word,
  output logic                         mul_valid,
  output logic [31:0]                  mul_result,
  output logic                         quot_busy
);

  localparam int W  = datapath_pkg::XLEN;
  localparam int HW = datapath_pkg::HALF_W;
  localparam int PW = datapath_pkg::PROD_W;
  localparam int AW = datapath_pkg::ACC_W;

  // ==========================================================================
  // Helpers
  function automatic logic fits(input logic [31:0] v, input logic [5:0] w, input logic sgn);
    logic [31:0] up;
    up = sgn ? 32'($signed(v) >>> (w - 6'h01)) : (v >> w);
    return (up == 32'h0000_0000) || (sgn && (up == 32'hffff_ffff));
  endfunction
  function automatic logic signed [49:0] mul_pass(input logic signed [32:0] a,
                                                  input logic signed [16:0] b);
    return a * b;
  endfunction
  function automatic logic [63:0] sext_prod(input logic [49:0] p);
    return {{(AW - PW){p[PW-1]}}, p};
  endfunction
  function automatic logic [63:0] acc_apply(input datapath_pkg::op_t op,
                                            input logic [63:0] acc,
                                            input logic [63:0] p);
    case (op)
      datapath_pkg::product_add_accumulate_op:      return acc + p;
      datapath_pkg::product_subtract_accumulate_op: return acc - p;
      default:                                      return p;
    endcase
  endfunction
  function automatic logic [31:0] neg_if(input logic [31:0] v, input logic c);
    return c ? 32'(-v) : v;
  endfunction
  function automatic logic [5:0] lead_count(input logic [31:0] v);
    for (int i = W - 1; i >= 0; i--) begin
      if (v[i]) begin
        return 6'(W - 1 - i);
      end
    end
    return 6'(W);
  endfunction

  // ==========================================================================
  // State
  logic [31:0]                regs_q [0:datapath_pkg::BANK_WORDS-1];
  logic                       wb_valid_q;
  logic                       wb_bank_q;
  logic [4:0]                 wb_addr_q;
  logic [31:0]                wb_data_q;
  logic                       load_pend_q;
  logic                       load_bank_q;
  logic [4:0]                 load_dst_q;
  logic                       mem_re_q;
  logic                       mem_we_q;
  logic [31:0]                mem_addr_q;
  logic [31:0]                mem_wdata_q;
  logic [31:0]                top_q;
  logic [31:0]                bottom_q;
  logic                       pend_q;
  datapath_pkg::op_t          pend_op_q;
  logic signed [32:0]         pa_q;
  logic signed [16:0]         pb_q;
  logic [49:0]                plo_q;
  logic                       stage_v_q;
  logic [31:0]                stage_q;
  logic                       mul_valid_q;
  logic [31:0]                mul_result_q;
  datapath_pkg::quot_state_t  quot_state_q;
  logic [5:0]                 cnt_q;
  logic [5:0]                 iters_q;
  logic [31:0]                dq_q;
  logic [32:0]                rem_q;
  logic [31:0]                dsr_q;
  logic                       neg_q_q;
  logic                       neg_r_q;

  // ==========================================================================
  // Register read with forwarding
  wire        fwd_a     = wb_valid_q && (wb_bank_q == shadow_sel) && (wb_addr_q == src_a_addr);
  wire        fwd_b     = wb_valid_q && (wb_bank_q == shadow_sel) && (wb_addr_q == src_b_addr);
  wire [31:0] operand_a = fwd_a ? wb_data_q : regs_q[{shadow_sel, src_a_addr}];
  wire [31:0] operand_b = fwd_b ? wb_data_q : regs_q[{shadow_sel, src_b_addr}];
  wire [31:0] alu_b     = use_imm ? imm : operand_b;

  // ==========================================================================
  // Issue decode and interlocks
  wire is_acc_prod = iss_op inside {datapath_pkg::product_to_accumulator_op,
                                    datapath_pkg::product_add_accumulate_op,
                                    datapath_pkg::product_subtract_accumulate_op};
  wire is_reg_prod = iss_op == datapath_pkg::product_to_register_op;
  wire is_prod     = is_acc_prod || is_reg_prod;
  wire is_quot     = iss_op == datapath_pkg::quotient_op;
  wire is_move     = iss_op inside {datapath_pkg::move_top_op, datapath_pkg::move_bottom_op};
  wire is_load     = iss_op == datapath_pkg::load_word_op;
  wire is_store    = iss_op == datapath_pkg::store_word_op;
  wire is_unit     = is_prod || is_quot || is_move;
  wire b_short     = fits(operand_b, 6'(HW), iss_signed);
  wire is_long     = is_prod && !b_short;
  wire quot_active = quot_state_q == datapath_pkg::quot_run;
  wire quot_fin    = quot_active && (cnt_q == datapath_pkg::CNT_LAST);
  wire quot_wait   = quot_active && (cnt_q > datapath_pkg::CNT_LAST);

  assign iss_stall = iss_valid && (load_pend_q
                     || (is_unit && quot_wait)
                     || (is_move && (quot_active || pend_q))
                     || (is_long && pend_q)
                     || (is_reg_prod && pend_q));
  wire take        = iss_valid && !iu_hold && !iss_stall;

  // ==========================================================================
  // Multiplier passes
  wire        [32:0] a33      = {iss_signed & operand_a[W-1], operand_a};
  wire        [16:0] b_lo17   = {iss_signed & b_short & operand_b[HW-1], operand_b[HW-1:0]};
  wire        [16:0] b_hi17   = {iss_signed & operand_b[W-1], operand_b[W-1:HW]};
  wire signed [49:0] p_first  = mul_pass(a33, b_lo17);
  wire signed [49:0] p_second = mul_pass(pa_q, pb_q);
  wire        [63:0] prod_short = sext_prod(p_first);
  wire        [63:0] prod_long  = (sext_prod(p_second) << HW) + sext_prod(plo_q);

  // ==========================================================================
  // Quotient step and setup
  wire        qa_neg  = iss_signed & operand_a[W-1];
  wire        qb_neg  = iss_signed & operand_b[W-1];
  wire [31:0] mag_a   = neg_if(operand_a, qa_neg);
  wire [31:0] mag_b   = neg_if(operand_b, qb_neg);
  wire        f8      = fits(operand_a, datapath_pkg::FIT_8, iss_signed);
  wire        f16     = fits(operand_a, datapath_pkg::FIT_16, iss_signed);
  wire        f24     = fits(operand_a, datapath_pkg::FIT_24, iss_signed);
  wire [5:0]  skip    = f8 ? datapath_pkg::SKIP_8 : f16 ? datapath_pkg::SKIP_16 :
                        f24 ? datapath_pkg::SKIP_24 : datapath_pkg::SKIP_32;
  wire [5:0]  rpt     = f8 ? datapath_pkg::RPT_8 : f16 ? datapath_pkg::RPT_16 :
                        f24 ? datapath_pkg::RPT_24 : datapath_pkg::RPT_32;
  wire        step    = quot_active && (cnt_q <= iters_q);
  wire [32:0] rem_t   = {rem_q[W-1:0], dq_q[W-1]};
  wire        ge      = rem_t >= {1'b0, dsr_q};
  wire [32:0] rem_n   = ge ? 33'(rem_t - {1'b0, dsr_q}) : rem_t;
  wire [31:0] dq_n    = {dq_q[W-2:0], ge};
  wire        quot_load = take && is_quot;

  // ==========================================================================
  // Result pair update, in program order
  wire [63:0] acc_now = {top_q, bottom_q};
  wire [63:0] acc_a   = quot_fin ? {neg_if(rem_n[W-1:0], neg_r_q), neg_if(dq_n, neg_q_q)} : acc_now;
  wire        pend_acc = pend_q && (pend_op_q != datapath_pkg::product_to_register_op);
  wire [63:0] acc_b   = pend_acc ? acc_apply(pend_op_q, acc_a, prod_long) : acc_a;
  wire        short_acc = take && is_acc_prod && b_short;
  wire [63:0] acc_c   = short_acc ? acc_apply(iss_op, acc_b, prod_short) : acc_b;
  wire        stage_v_d = (take && is_reg_prod && b_short) || (pend_q && !pend_acc);
  wire [31:0] stage_d   = pend_q ? prod_long[W-1:0] : prod_short[W-1:0];

  // ==========================================================================
  // Arithmetic logic unit
  wire [4:0]  shamt = alu_b[datapath_pkg::SHAMT_W-1:0];
  wire        lt    = iss_signed ? ($signed(operand_a) < $signed(alu_b)) : (operand_a < alu_b);
  wire [5:0]  lead  = lead_count((iss_op == datapath_pkg::count_leading_ones_op) ? ~operand_a : operand_a);
  logic [31:0] alu_res;

  always_comb begin
    case (iss_op)
      datapath_pkg::alu_add_op:             alu_res = operand_a + alu_b;
      datapath_pkg::alu_sub_op:             alu_res = operand_a - alu_b;
      datapath_pkg::alu_and_op:             alu_res = operand_a & alu_b;
      datapath_pkg::alu_or_op:              alu_res = operand_a | alu_b;
      datapath_pkg::alu_xor_op:             alu_res = operand_a ^ alu_b;
      datapath_pkg::alu_nor_op:             alu_res = ~(operand_a | alu_b);
      datapath_pkg::alu_sll_op:             alu_res = operand_a << shamt;
      datapath_pkg::alu_srl_op:             alu_res = operand_a >> shamt;
      datapath_pkg::alu_sra_op:             alu_res = 32'($signed(operand_a) >>> shamt);
      datapath_pkg::alu_slt_op:             alu_res = {31'h0000_0000, lt};
      datapath_pkg::count_leading_zeros_op: alu_res = {26'h000_0000, lead};
      datapath_pkg::count_leading_ones_op:  alu_res = {26'h000_0000, lead};
      datapath_pkg::move_top_op:            alu_res = top_q;
      datapath_pkg::move_bottom_op:         alu_res = bottom_q;
      default:                              alu_res = 32'h0000_0000;
    endcase
  end

  wire alu_wr = take && !is_prod && !is_quot && !is_load && !is_store;

  // ==========================================================================
  // Register banks, no reset on storage
  always_ff @(posedge clk) begin
    if (wb_valid_q) begin
      regs_q[{wb_bank_q, wb_addr_q}] <= wb_data_q;
    end
  end

  // ==========================================================================
  // Write-back and memory stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_valid_q  <= 1'b0;
      wb_bank_q   <= 1'b0;
      wb_addr_q   <= 5'h00;
      wb_data_q   <= 32'h0000_0000;
      load_pend_q <= 1'b0;
      load_bank_q <= 1'b0;
      load_dst_q  <= 5'h00;
      mem_re_q    <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_addr_q  <= 32'h0000_0000;
      mem_wdata_q <= 32'h0000_0000;
    end else begin
      wb_valid_q  <= alu_wr || load_pend_q;
      wb_bank_q   <= load_pend_q ? load_bank_q : shadow_sel;
      wb_addr_q   <= load_pend_q ? load_dst_q : dst_addr;
      wb_data_q   <= load_pend_q ? load_data : alu_res;
      load_pend_q <= take && is_load;
      load_bank_q <= shadow_sel;
      load_dst_q  <= dst_addr;
      mem_re_q    <= take && is_load;
      mem_we_q    <= take && is_store;
      if (take && (is_load || is_store)) begin
        mem_addr_q  <= operand_a + imm;
        mem_wdata_q <= operand_b;
      end
    end
  end

  // ==========================================================================
  // Multiply pipeline, runs regardless of iu_hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      top_q        <= 32'h0000_0000;
      bottom_q     <= 32'h0000_0000;
      pend_q       <= 1'b0;
      pend_op_q    <= datapath_pkg::product_to_accumulator_op;
      pa_q         <= 33'h0_0000_0000;
      pb_q         <= 17'h0_0000;
      plo_q        <= 50'h0_0000_0000_0000;
      stage_v_q    <= 1'b0;
      stage_q      <= 32'h0000_0000;
      mul_valid_q  <= 1'b0;
      mul_result_q <= 32'h0000_0000;
    end else begin
      {top_q, bottom_q} <= acc_c;
      pend_q       <= take && is_long;
      if (take && is_long) begin
        pend_op_q <= iss_op;
        pa_q      <= a33;
        pb_q      <= b_hi17;
        plo_q     <= p_first;
      end
      stage_v_q    <= stage_v_d;
      stage_q      <= stage_d;
      mul_valid_q  <= stage_v_q;
      mul_result_q <= stage_q;
    end
  end

  // ==========================================================================
  // Divide state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quot_state_q <= datapath_pkg::quot_idle;
      cnt_q        <= datapath_pkg::CNT_ZERO;
      iters_q      <= datapath_pkg::CNT_ZERO;
      dq_q         <= 32'h0000_0000;
      rem_q        <= 33'h0_0000_0000;
      dsr_q        <= 32'h0000_0000;
      neg_q_q      <= 1'b0;
      neg_r_q      <= 1'b0;
    end else if (quot_load) begin
      quot_state_q <= datapath_pkg::quot_run;
      cnt_q        <= rpt;
      iters_q      <= datapath_pkg::FULL_ITER - skip;
      dq_q         <= mag_a << skip;
      rem_q        <= 33'h0_0000_0000;
      dsr_q        <= mag_b;
      neg_q_q      <= qa_neg ^ qb_neg;
      neg_r_q      <= qa_neg;
    end else begin
      case (quot_state_q)
        datapath_pkg::quot_run: begin
          cnt_q <= cnt_q - datapath_pkg::CNT_LAST;
          if (step) begin
            rem_q <= rem_n;
            dq_q  <= dq_n;
          end
          if (quot_fin) begin
            quot_state_q <= datapath_pkg::quot_idle;
          end
        end
        datapath_pkg::quot_idle: begin
          cnt_q <= datapath_pkg::CNT_ZERO;
        end
        default: begin
          quot_state_q <= datapath_pkg::quot_idle;
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  assign mem_re             = mem_re_q;
  assign mem_we             = mem_we_q;
  assign mem_addr           = mem_addr_q;
  assign mem_wdata          = mem_wdata_q;
  assign wb_valid           = wb_valid_q;
  assign wb_bank            = wb_bank_q;
  assign wb_addr            = wb_addr_q;
  assign wb_data            = wb_data_q;
  assign top_result_word    = top_q;
  assign bottom_result_word = bottom_q;
  assign mul_valid          = mul_valid_q;
  assign mul_result         = mul_result_q;
  assign quot_busy          = quot_active;

endmodule

// ==== test/multiply_divide_datapath_chk.sv ====
// Port checker for the integer datapath.
// Assumes one clock domain, bound to the top module.
`timescale 1ns/1ns
module multiply_divide_datapath_chk (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // Issue
  input wire logic              iss_valid,
  input wire datapath_pkg::op_t iss_op,
  input wire logic [4:0]        dst_addr,
  input wire logic              shadow_sel,
  input wire logic              iu_hold,
  input wire logic              iss_stall,
  // Answers
  input wire logic              mem_re,
  input wire logic              mem_we,
  input wire logic              wb_valid,
  input wire logic              wb_bank,
  input wire logic [4:0]        wb_addr,
  input wire logic              mul_valid,
  input wire logic              quot_busy
);
  // ====================
  // Properties
  wire take   = iss_valid && !iss_stall && !iu_hold;
  wire alu_op = iss_op <= datapath_pkg::count_leading_ones_op;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  load_strobe_a: assert property (take && iss_op == datapath_pkg::load_word_op |=> mem_re)
    else $error("load without read strobe");
  store_src_a: assert property (mem_we |-> $past(take && iss_op == datapath_pkg::store_word_op))
    else $error("write strobe without store");
  alu_wb_a: assert property (take && alu_op |=> wb_valid && wb_addr == $past(dst_addr))
    else $error("alu result not written");
  bank_sel_a: assert property (take && alu_op |=> wb_bank == $past(shadow_sel))
    else $error("wrong bank written");
  quot_start_a: assert property (take && iss_op == datapath_pkg::quotient_op |=> quot_busy)
    else $error("division did not start");
  quot_min_a: assert property ($rose(quot_busy) |-> quot_busy[*8])
    else $error("division ended too early");
  quot_hold_a: assert property (quot_busy && iss_valid && iss_op == datapath_pkg::move_top_op |-> iss_stall)
    else $error("move taken during division");
  mulreg_lat_a: assert property (take && iss_op == datapath_pkg::product_to_register_op |-> ##[2:3] mul_valid)
    else $error("product result late");
  stall_once_a: assert property (iss_stall && !quot_busy |=> !iss_stall)
    else $error("stall outlasts interlock");
  cover property ($fell(quot_busy));
  cover property (mul_valid);
  cover property (iss_stall && iss_op == datapath_pkg::product_to_accumulator_op);
endmodule

bind multiply_divide_datapath multiply_divide_datapath_chk chk (.clk, .rst_b, .iss_valid, .iss_op, .dst_addr,
  .shadow_sel, .iu_hold, .iss_stall, .mem_re, .mem_we, .wb_valid, .wb_bank, .wb_addr, .mul_valid, .quot_busy);

// ==== test/issue_model.sv ====
// Integer pipeline model: issues operations, answers loads.
// Assumes issue is called just after a rising edge.
`timescale 1ns/1ns
module issue_model (
  // Clock and unit answers
  input wire logic          clk,
  input wire logic          iss_stall,
  input wire logic          mem_re,
  input wire logic [31:0]   mem_addr,
  // Issue side
  output datapath_pkg::op_t iss_op,
  output logic [4:0]        src_a_addr,
  output logic [4:0]        src_b_addr,
  output logic [4:0]        dst_addr,
  output logic [31:0]       imm,
  output logic [31:0]       load_data,
  output logic              iss_valid,
  output logic              iss_signed,
  output logic              use_imm,
  output logic              shadow_sel,
  output logic              iu_hold
);
  int stalls;
  // Data only during the strobe, scrambled otherwise
  assign load_data = mem_re ? mem_addr ^ 32'h0000ffff : ~mem_addr;
  initial begin
    {iss_valid, iss_signed, use_imm, shadow_sel, iu_hold} = 0;
    iss_op = datapath_pkg::alu_add_op;
    {src_a_addr, src_b_addr, dst_addr, imm} = 0;
  end
  task issue(input datapath_pkg::op_t op, input logic [4:0] a, b, d, input logic [31:0] im, input logic ui, sg);
    logic t;
    iss_op = op;
    {iss_valid, src_a_addr, src_b_addr, dst_addr, imm, use_imm, iss_signed} = {1'b1, a, b, d, im, ui, sg};
    stalls = 0;
    do begin
      @(negedge clk);
      t = !iss_stall && !iu_hold;
      stalls += !t;
      @(posedge clk);
    end while (!t);
    #1;
  endtask
  task idle;
    iss_valid = 0;
  endtask
  task set_ctl(input logic h, input logic s);
    iu_hold = h;
    shadow_sel = s;
  endtask
endmodule

// ==== test/multiply_divide_datapath_bench.sv ====
// Self-checking bench for the datapath and its product/quotient unit.
// Assumes the checker is bound and the issue model drives requests.
`timescale 1ns/1ns
module multiply_divide_datapath_bench;
  // ====================
  // Signals
  logic              clk = 0, rst_b = 0;
  logic              iss_valid, iss_signed, use_imm, shadow_sel, iu_hold, iss_stall;
  logic              mem_re, mem_we, wb_valid, wb_bank, mul_valid, quot_busy;
  logic [4:0]        src_a_addr, src_b_addr, dst_addr, wb_addr;
  logic [31:0]       imm, mem_addr, mem_wdata, load_data, wb_data, mul_result;
  logic [31:0]       top_result_word, bottom_result_word;
  logic [31:0]       rv [8];
  logic [63:0]       p;
  datapath_pkg::op_t iss_op;
  int                error_cnt = 0, checks_done = 0;
  multiply_divide_datapath dut (.*);
  issue_model ipm (.*);
  always #10 clk = ~clk;
  // ====================
  // Helpers
  task chk(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task summarize;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task set_reg(input logic [4:0] r, input logic [31:0] v);
    ipm.issue(datapath_pkg::alu_and_op, r, 0, r, 0, 1, 0);
    chk(wb_data, 0, "clear");
    ipm.issue(datapath_pkg::alu_or_op, r, 0, r, v, 1, 0);
    chk(wb_data, v, "forward");
    rv[r] = v;
  endtask
  // ====================
  // Scenarios
  task s_alu;
    set_reg(1, 32'h00000064);
    set_reg(2, 32'h00000007);
    set_reg(3, 32'h12345678);
    set_reg(4, 32'hfffffffd);
    set_reg(6, 32'h00001234);
    set_reg(7, 32'h00123456);
    ipm.issue(datapath_pkg::alu_sub_op, 1, 2, 5, 0, 0, 0);
    chk(wb_data, 32'h0000005d, "sub");
    ipm.issue(datapath_pkg::count_leading_zeros_op, 3, 0, 5, 0, 0, 0);
    chk(wb_data, 32'h00000003, "zeros");
    ipm.issue(datapath_pkg::count_leading_ones_op, 4, 0, 5, 0, 0, 0);
    chk(wb_data, 32'h0000001e, "ones");
    ipm.issue(datapath_pkg::alu_sra_op, 4, 0, 5, 32'h00000001, 1, 0);
    chk(wb_data, 32'hfffffffe, "sra");
    ipm.issue(datapath_pkg::alu_slt_op, 4, 2, 5, 0, 0, 1);
    chk(wb_data, 32'h00000001, "slt");
  endtask
  task s_mul;
    ipm.issue(datapath_pkg::product_to_accumulator_op, 1, 2, 0, 0, 0, 0);
    chk(bottom_result_word, 32'h000002bc, "short");
    p = rv[1] * 64'(rv[3]);
    ipm.issue(datapath_pkg::product_to_accumulator_op, 1, 3, 0, 0, 0, 0);
    chk(bottom_result_word, 32'h000002bc, "full early");
    ipm.issue(datapath_pkg::product_to_accumulator_op, 1, 3, 0, 0, 0, 0);
    chk(ipm.stalls, 1, "interlock");
    chk(top_result_word, p[63:32], "top");
    chk(bottom_result_word, p[31:0], "bottom");
    ipm.issue(datapath_pkg::product_add_accumulate_op, 1, 2, 0, 0, 0, 0);
    chk(ipm.stalls, 0, "short after full");
    chk(bottom_result_word, p[31:0] + 32'h000002bc, "add");
    ipm.issue(datapath_pkg::product_subtract_accumulate_op, 1, 3, 0, 0, 0, 0);
    ipm.idle;
    step(1);
    chk(top_result_word, 0, "sub top");
    chk(bottom_result_word, 32'h000002bc, "sub bottom");
    ipm.issue(datapath_pkg::product_to_accumulator_op, 4, 2, 0, 0, 0, 1);
    chk(top_result_word, 32'hffffffff, "signed top");
    chk(bottom_result_word, 32'hffffffeb, "signed");
  endtask
  task s_mreg(input logic [4:0] b, input int lat);
    p = rv[1] * 64'(rv[b]);
    ipm.issue(datapath_pkg::product_to_register_op, 1, b, 0, 0, 0, 0);
    ipm.idle;
    step(lat - 2);
    chk(mul_valid, 0, "early");
    step(1);
    chk(mul_valid, 1, "valid");
    chk(mul_result, p[31:0], "result");
  endtask
  task s_div(input logic [4:0] a, input int r);
    int n;
    ipm.issue(datapath_pkg::quotient_op, a, 2, 0, 0, 0, 0);
    ipm.idle;
    n = 1;
    while (quot_busy === 1'b1 && n < 40) begin
      ipm.set_ctl(n > 1 && n < 6, 0);
      step(1);
      n++;
    end
    chk(n, r + 1, "busy");
    chk(bottom_result_word, rv[a] / rv[2], "quotient");
    chk(top_result_word, rv[a] % rv[2], "remainder");
  endtask
  task s_stall;
    ipm.issue(datapath_pkg::quotient_op, 1, 2, 0, 0, 0, 0);
    ipm.issue(datapath_pkg::move_top_op, 0, 0, 5, 0, 0, 0);
    chk(ipm.stalls, 11, "move held");
    chk(wb_data, 32'h00000002, "moved");
  endtask
  task s_mem;
    ipm.issue(datapath_pkg::store_word_op, 1, 2, 0, 32'h00000010, 0, 0);
    chk(mem_we, 1, "store");
    chk(mem_addr, 32'h00000074, "addr");
    chk(mem_wdata, rv[2], "wdata");
    ipm.issue(datapath_pkg::load_word_op, 3, 0, 5, 0, 0, 0);
    chk(mem_re, 1, "load");
    ipm.idle;
    step(1);
    chk(wb_data, rv[3] ^ 32'h0000ffff, "load data");
  endtask
  task s_bank;
    ipm.set_ctl(0, 1);
    set_reg(5, 32'h0000abcd);
    ipm.set_ctl(0, 0);
    ipm.issue(datapath_pkg::alu_add_op, 5, 0, 6, 0, 1, 0);
    chk(wb_data, rv[3] ^ 32'h0000ffff, "normal bank");
    ipm.set_ctl(0, 1);
    ipm.issue(datapath_pkg::alu_add_op, 5, 0, 6, 0, 1, 0);
    chk(wb_data, 32'h0000abcd, "shadow bank");
    ipm.idle;
    ipm.set_ctl(0, 0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1;
    step(1);
    s_alu;
    s_mul;
    s_mreg(2, 2);
    s_mreg(3, 3);
    s_div(1, 11);
    s_div(6, 18);
    s_div(7, 25);
    s_div(3, 32);
    s_stall;
    s_mem;
    s_bank;
    summarize;
  end
  initial begin
    #100000;
    error_cnt++;
    summarize;
  end
endmodule
